//--- core/acs_pkg.sv
// Package with the register map, field layout and timing of the converter control.
package acs_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int NUM_CH = 4;
  localparam int CNT_W = 16;
  localparam int RES_W = 12;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } acs_bus_req_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SETTLE = 4'h2,
    ST_CONV = 4'h4,
    ST_NEXT = 4'h8
  } acs_state_t;

  localparam logic [ADDR_W-1:0] OFS_RESET_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CLK_ENABLE = 5'h01;
  localparam logic [ADDR_W-1:0] OFS_MODE_ZERO = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_MODE_ONE = 5'h03;
  localparam logic [ADDR_W-1:0] OFS_MODE_TWO = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_UPPER_LIMIT = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_LOWER_LIMIT = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_PORT_ANALOG = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_PORT_DIR = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h09;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h0A;
  localparam logic [ADDR_W-1:0] OFS_IRQ_PRIO = 5'h0B;
  localparam logic [ADDR_W-1:0] OFS_ENGINE_STATE = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_RESULT0 = 5'h0D;
  localparam logic [ADDR_W-1:0] OFS_PORT_IN = 5'h11;

  localparam int BIT_CONV_RESET = 5;
  localparam int BIT_CLK_GATE = 5;
  localparam int BIT_RUN = 7;
  localparam int BIT_CH_MODE = 6;
  localparam int BIT_TIME_HI = 5;
  localparam int BIT_TIME_LO = 1;
  localparam int BIT_COMP = 0;
  localparam int BIT_TRIG_HI = 7;
  localparam int BIT_TRIG_LO = 6;
  localparam int BIT_REPEAT = 5;
  localparam int BIT_SRC_HI = 1;
  localparam int BIT_SRC_LO = 0;
  localparam int BIT_IRQ_END = 0;
  localparam int BIT_IRQ_BADCODE = 1;

  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] MODE_ONE_WMASK = 8'hE3;
  localparam logic [7:0] MODE_TWO_WMASK = 8'hED;
  localparam logic [7:0] RST_UPPER = 8'hFF;
  localparam logic [7:0] RST_LOWER = 8'h00;
  localparam logic [3:0] RST_PORT_ANALOG = 4'hF;
  localparam logic [3:0] RST_PORT_DIR = 4'hF;
  localparam logic [1:0] RST_IRQ_MASK = 2'h3;
  localparam logic [1:0] RST_IRQ_PRIO = 2'h3;

  localparam int CLK_MHZ = 10;
  localparam int T_CONV_9_NS = 9000;
  localparam int T_CONV_54_NS = 54000;
  localparam int T_CONV_40_NS = 40500;
  localparam int T_CONV_33_NS = 33750;
  localparam int T_CONV_27_NS = 27000;
  localparam int T_CONV_13_NS = 13500;
  localparam int T_CONV_66_NS = 66000;
  localparam int T_SETTLE_NS = 1000;
  localparam int CYC_CONV_9 = (T_CONV_9_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_CONV_54 = (T_CONV_54_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_CONV_40 = (T_CONV_40_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_CONV_33 = (T_CONV_33_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_CONV_27 = (T_CONV_27_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_CONV_13 = (T_CONV_13_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_CONV_66 = (T_CONV_66_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_SETTLE = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;

endpackage

//--- core/acs_sync.sv
// Two-stage synchroniser for the port 1 pin levels.
`timescale 1ns/1ps
module acs_sync (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [3:0] async_in,
  output logic [3:0] sync_out
);
  import acs_pkg::*;

  logic [3:0] stage_one;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      stage_one <= 4'h0;
      sync_out <= 4'h0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule

//--- core/acs_timer.sv
// Down counter that times the settle wait and each conversion.
`timescale 1ns/1ps
module acs_timer (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic load,
  input wire logic [acs_pkg::CNT_W-1:0] load_val,
  input wire logic hold,
  input wire logic abort,
  output logic done
);
  import acs_pkg::*;

  logic [CNT_W-1:0] count;

  // The pulse comes in the last cycle of the loaded span.
  assign done = (count == 16'h0001) && !hold && !abort;

  always_ff @(posedge core_clk) begin
    if (srst || abort) begin
      count <= 16'h0000;
    end else if (load) begin
      count <= load_val;
    end else if (!hold && count != 16'h0000) begin
      count <= count - 16'h0001;
    end
  end
endmodule

//--- core/acs_adc_control.sv
// Converter control: registers, trigger selection, conversion sequencer.
`timescale 1ns/1ps
module acs_adc_control (
  input wire logic core_clk,
  input wire logic srst,
  input wire acs_pkg::acs_bus_req_t bus_req,
  output logic [acs_pkg::DATA_W-1:0] bus_rdata,
  input wire logic timer_one_end_event,
  input wire logic event_link_controller,
  input wire logic realtime_clock_event,
  input wire logic interval_timer_event,
  output logic comparator_on,
  output logic conv_start,
  output logic [1:0] conv_channel,
  input wire logic [acs_pkg::RES_W-1:0] conv_data,
  output logic irq,
  output logic [1:0] irq_priority,
  output logic [3:0] p1_analog_route,
  input wire logic [3:0] p1_pin_in,
  input wire logic [3:0] p1_port_data,
  output logic [3:0] p1_pin_out,
  output logic [3:0] p1_pin_oe
);
  import acs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic converter_reset_bit;
  logic converter_clock_gate;
  logic [7:0] converter_mode_zero;
  logic [7:0] converter_mode_one;
  logic [7:0] converter_mode_two;
  logic [7:0] upper_compare_limit;
  logic [7:0] lower_compare_limit;
  logic [3:0] port1_analog_select;
  logic [3:0] port1_direction;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] irq_prio;
  logic [RES_W-1:0] result [NUM_CH];
  logic [3:0] port_in_sync;
  logic sw_pending;
  acs_state_t st;
  acs_state_t next_st;

  function automatic logic wr_at(acs_bus_req_t r, logic [ADDR_W-1:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // Zero marks a prohibited code, so no conversion may start with it.
  function automatic logic [CNT_W-1:0] conv_cycles(logic [4:0] code);
    logic [CNT_W-1:0] c;
    c = 16'h0000;
    if (code[1:0] == 2'h0) begin
      case (code[4:2])
        3'h0: c = CNT_W'(CYC_CONV_9);
        3'h2: c = CNT_W'(CYC_CONV_54);
        3'h3: c = CNT_W'(CYC_CONV_40);
        3'h4: c = CNT_W'(CYC_CONV_33);
        3'h5: c = CNT_W'(CYC_CONV_27);
        3'h6: c = CNT_W'(CYC_CONV_13);
        3'h7: c = CNT_W'(CYC_CONV_66);
        default: c = 16'h0000;
      endcase
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wire conv_held = converter_reset_bit;
  wire conv_active = converter_clock_gate && !converter_reset_bit;
  wire conversion_run = converter_mode_zero[BIT_RUN];
  wire channel_select_mode = converter_mode_zero[BIT_CH_MODE];
  wire comparator_enable = converter_mode_zero[BIT_COMP];
  wire [4:0] conv_time_code =
    converter_mode_zero[BIT_TIME_HI:BIT_TIME_LO];
  wire trigger_mode_hi = converter_mode_one[BIT_TRIG_HI];
  wire trigger_mode_lo = converter_mode_one[BIT_TRIG_LO];
  wire conversion_repeat_mode = converter_mode_one[BIT_REPEAT];
  wire [1:0] hw_trigger_source =
    converter_mode_one[BIT_SRC_HI:BIT_SRC_LO];
  wire [CNT_W-1:0] conv_len_sel = conv_cycles(conv_time_code);
  wire code_ok = (conv_len_sel != 16'h0000);
  wire wait_mode = trigger_mode_hi && trigger_mode_lo;

  wire hw_trig =
    (hw_trigger_source == 2'h0) ? timer_one_end_event :
    (hw_trigger_source == 2'h1) ? event_link_controller :
    (hw_trigger_source == 2'h2) ? realtime_clock_event :
    interval_timer_event;

  wire start_ok = trigger_mode_hi ? hw_trig : sw_pending;
  // no start when held or unclocked
  wire start_try = conv_active && conversion_run && comparator_enable &&
    (st == ST_IDLE) && start_ok;
  wire go = start_try && code_ok;
  wire bad_code = start_try && !code_ok;
  // scan ends after the fourth channel
  wire last_ch = !channel_select_mode || (conv_channel == 2'h3);
  wire seq_end = (st == ST_NEXT) && last_ch && conv_active;
  wire [7:0] res_hi = conv_data[RES_W-1:RES_W-8];
  wire in_limits = (res_hi >= lower_compare_limit) &&
    (res_hi <= upper_compare_limit);
  wire tmr_done;
  wire tmr_load = go || ((st == ST_SETTLE) && tmr_done) ||
    ((st == ST_NEXT) && (next_st == ST_CONV));
  wire [CNT_W-1:0] tmr_val =
    ((st == ST_IDLE) && wait_mode) ? CNT_W'(CYC_SETTLE) : conv_len_sel;
  wire tmr_abort = (next_st == ST_IDLE);
  wire end_event = seq_end && in_limits;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    if (conv_held) begin
      next_st = ST_IDLE;
    end else if (!converter_clock_gate) begin
      next_st = st;
    end else if (!conversion_run) begin
      next_st = ST_IDLE;
    end else begin
      case (st)
        ST_IDLE: begin
          if (go) begin
            next_st = wait_mode ? ST_SETTLE : ST_CONV;
          end
        end
        ST_SETTLE: begin
          if (tmr_done) begin
            next_st = ST_CONV;
          end
        end
        ST_CONV: begin
          if (tmr_done) begin
            next_st = ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (last_ch && conversion_repeat_mode) begin
            next_st = ST_IDLE;
          end else begin
            next_st = ST_CONV;
          end
        end
        default: next_st = ST_IDLE;
      endcase
    end
  end

  acs_timer u_timer (
    .core_clk(core_clk),
    .srst(srst),
    .load(tmr_load),
    .load_val(tmr_val),
    .hold(!converter_clock_gate),
    .abort(tmr_abort),
    .done(tmr_done)
  );

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= ST_IDLE;
      conv_channel <= 2'h0;
      conv_start <= 1'b0;
    end else begin
      st <= next_st;
      conv_start <= tmr_load && (tmr_val == conv_len_sel) &&
        !(st == ST_IDLE && wait_mode);
      if (next_st == ST_IDLE || go) begin
        conv_channel <= 2'h0;
      end else if (st == ST_NEXT && converter_clock_gate) begin
        conv_channel <= last_ch ? 2'h0 : conv_channel + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || conv_held) begin
      for (int i = 0; i < NUM_CH; i++) begin
        result[i] <= 12'h000;
      end
    end else if ((st == ST_CONV) && tmr_done) begin
      result[conv_channel] <= conv_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writes to converter registers are lost while its clock is stopped.
  always_ff @(posedge core_clk) begin
    if (srst || conv_held) begin
      converter_mode_zero <= RST_MODE;
      converter_mode_one <= RST_MODE;
      converter_mode_two <= RST_MODE;
      upper_compare_limit <= RST_UPPER;
      lower_compare_limit <= RST_LOWER;
      sw_pending <= 1'b0;
    end else if (converter_clock_gate) begin
      if (wr_at(bus_req, OFS_MODE_ZERO)) begin
        converter_mode_zero <= bus_req.wdata[7:0];
      // one-shot software pass clears the run bit
      end else if (seq_end && !trigger_mode_hi && conversion_repeat_mode) begin
        converter_mode_zero[BIT_RUN] <= 1'b0;
      end
      if (wr_at(bus_req, OFS_MODE_ONE)) begin
        converter_mode_one <= bus_req.wdata[7:0] & MODE_ONE_WMASK;
      end
      if (wr_at(bus_req, OFS_MODE_TWO)) begin
        converter_mode_two <= bus_req.wdata[7:0] & MODE_TWO_WMASK;
      end
      if (wr_at(bus_req, OFS_UPPER_LIMIT)) begin
        upper_compare_limit <= bus_req.wdata[7:0];
      end
      if (wr_at(bus_req, OFS_LOWER_LIMIT)) begin
        lower_compare_limit <= bus_req.wdata[7:0];
      end
      // software start is a write that raises the run bit
      if (wr_at(bus_req, OFS_MODE_ZERO) && bus_req.wdata[BIT_RUN] &&
          !conversion_run) begin
        sw_pending <= 1'b1;
      end else if (go || !conversion_run) begin
        sw_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      converter_reset_bit <= 1'b0;
      converter_clock_gate <= 1'b0;
      port1_analog_select <= RST_PORT_ANALOG;
      port1_direction <= RST_PORT_DIR;
      irq_mask <= RST_IRQ_MASK;
      irq_prio <= RST_IRQ_PRIO;
    end else begin
      if (wr_at(bus_req, OFS_RESET_CTRL)) begin
        converter_reset_bit <= bus_req.wdata[BIT_CONV_RESET];
      end
      if (wr_at(bus_req, OFS_CLK_ENABLE)) begin
        converter_clock_gate <= bus_req.wdata[BIT_CLK_GATE];
      end
      if (wr_at(bus_req, OFS_PORT_ANALOG)) begin
        port1_analog_select <= bus_req.wdata[3:0];
      end
      if (wr_at(bus_req, OFS_PORT_DIR)) begin
        port1_direction <= bus_req.wdata[3:0];
      end
      if (wr_at(bus_req, OFS_IRQ_MASK)) begin
        irq_mask <= bus_req.wdata[1:0];
      end
      if (wr_at(bus_req, OFS_IRQ_PRIO)) begin
        irq_prio <= bus_req.wdata[1:0];
      end
    end
  end

  // sticky flags, set wins over write-one-to-clear
  wire [1:0] irq_set = {bad_code, end_event};
  wire [1:0] irq_clr =
    wr_at(bus_req, OFS_IRQ_STATUS) ? bus_req.wdata[1:0] : 2'h0;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  // a mask bit of one blocks the request
  assign irq = |(irq_status & ~irq_mask);
  // priority level to the interrupt controller
  assign irq_priority = irq_prio;
  // comparator follows its own enable, not the run bit, while clocked and not held
  assign comparator_on = comparator_enable && conv_active;

  ////////////////////////////////////////////////////////////////////////////
  acs_sync u_pin_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in(p1_pin_in),
    .sync_out(port_in_sync)
  );

  assign p1_analog_route = port1_analog_select;
  // buffer on only for digital output pins
  assign p1_pin_oe = ~port1_direction & ~port1_analog_select;
  assign p1_pin_out = p1_port_data & p1_pin_oe;

  wire [ADDR_W-1:0] res_idx = bus_req.addr - OFS_RESULT0;
  wire res_hit = (bus_req.addr >= OFS_RESULT0) &&
    (bus_req.addr < OFS_PORT_IN);
  wire [DATA_W-1:0] rd_mux =
    (bus_req.addr == OFS_RESET_CTRL) ?
      16'(converter_reset_bit) << BIT_CONV_RESET :
    (bus_req.addr == OFS_CLK_ENABLE) ?
      16'(converter_clock_gate) << BIT_CLK_GATE :
    (bus_req.addr == OFS_MODE_ZERO) ? {8'h00, converter_mode_zero} :
    (bus_req.addr == OFS_MODE_ONE) ? {8'h00, converter_mode_one} :
    (bus_req.addr == OFS_MODE_TWO) ? {8'h00, converter_mode_two} :
    (bus_req.addr == OFS_UPPER_LIMIT) ? {8'h00, upper_compare_limit} :
    (bus_req.addr == OFS_LOWER_LIMIT) ? {8'h00, lower_compare_limit} :
    (bus_req.addr == OFS_PORT_ANALOG) ? {12'h000, port1_analog_select} :
    (bus_req.addr == OFS_PORT_DIR) ? {12'h000, port1_direction} :
    (bus_req.addr == OFS_IRQ_STATUS) ? {14'h0000, irq_status} :
    (bus_req.addr == OFS_IRQ_MASK) ? {14'h0000, irq_mask} :
    (bus_req.addr == OFS_IRQ_PRIO) ? {14'h0000, irq_prio} :
    (bus_req.addr == OFS_ENGINE_STATE) ?
      {10'h000, conv_channel, st} :
    res_hit ? {4'h0, result[res_idx[1:0]]} :
    (bus_req.addr == OFS_PORT_IN) ? {12'h000, port_in_sync} :
    16'h0000;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus_rdata <= 16'h0000;
    end else begin
      bus_rdata <= bus_req.rd ? rd_mux : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  logic [CNT_W-1:0] conv_len;

  always_ff @(posedge core_clk) begin
    if (srst || st != ST_CONV) begin
      conv_len <= 16'h0001;
    end else if (converter_clock_gate) begin
      conv_len <= conv_len + 16'h0001;
    end
  end

  sequence conv_leaving;
    (st == ST_CONV) && tmr_done;
  endsequence

  sequence idle_with_trigger;
    (st == ST_IDLE) && conv_active && conversion_run && comparator_enable &&
      trigger_mode_hi && hw_trig && code_ok;
  endsequence

  AST_RESET_HOLD: assert property (
    conv_held |=> (st == ST_IDLE) && !comparator_on)
    else $error("converter not held idle in reset");
  AST_GATE_FREEZE: assert property (
    (!converter_clock_gate && !conv_held) |=> $stable(st))
    else $error("sequencer moved without its clock");
  AST_RUN_STOP: assert property (
    (conv_active && !conversion_run) |=> (st == ST_IDLE))
    else $error("conversion continued with run bit low");
  AST_COMP_INDEP: assert property (
    ($fell(conversion_run) && comparator_enable && conv_active) |->
      comparator_on)
    else $error("comparator followed the run bit");
  AST_SELECT_CHAN: assert property (
    (!channel_select_mode && st == ST_CONV) |-> (conv_channel == 2'h0))
    else $error("select mode left channel zero");
  AST_CONV_TIME: assert property (
    conv_leaving |-> (conv_len == conv_len_sel))
    else $error("conversion time differs from selected code");
  AST_HW_START: assert property (
    idle_with_trigger |=> (st == (wait_mode ? ST_SETTLE : ST_CONV)))
    else $error("hardware trigger did not start conversion");
  AST_HW_IGNORE_SW: assert property (
    (st == ST_IDLE && trigger_mode_hi && !hw_trig) |=> (st == ST_IDLE))
    else $error("hardware mode started without trigger");
  AST_ONE_SHOT: assert property (
    (seq_end && conversion_repeat_mode && !trigger_mode_hi &&
      !wr_at(bus_req, OFS_MODE_ZERO)) |=> !conversion_run ##1
      (st == ST_IDLE))
    else $error("one-shot pass did not stop");
  AST_FLAG_SET: assert property (
    end_event |=> irq_status[BIT_IRQ_END] ##0
      (irq == !irq_mask[BIT_IRQ_END] || irq_status[BIT_IRQ_BADCODE]))
    else $error("conversion end flag or mask misbehaved");
  AST_PRIO: assert property (
    wr_at(bus_req, OFS_IRQ_PRIO) |=>
      (irq_priority == $past(bus_req.wdata[1:0])))
    else $error("priority write not applied");
  AST_PIN_BUF: assert property (
    ((p1_pin_oe & (port1_direction | port1_analog_select)) == 4'h0))
    else $error("output buffer on for input or analog pin");
  AST_NO_FLAG_OFF: assert property (
    !conv_active |-> (!seq_end && !start_try) ##1
      !$rose(irq_status[BIT_IRQ_END]))
    else $error("activity while held or unclocked");
endmodule

//--- testbench/acs_adc_control_tb_top.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
module acs_adc_control_tb_top;
  import acs_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  acs_bus_req_t bus_req = '0;
  logic [DATA_W-1:0] bus_rdata;
  logic [3:0] trig = 4'h0;
  logic [RES_W-1:0] conv_data = 12'h5A3;
  logic [3:0] p1_pin_in = 4'h9;
  logic [3:0] p1_port_data = 4'hF;
  logic comparator_on, conv_start, irq;
  logic [1:0] conv_channel, irq_priority;
  logic [3:0] p1_analog_route, p1_pin_out, p1_pin_oe;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  int n, d0;

  always #50 core_clk = ~core_clk;

  acs_adc_control uut (
    .core_clk(core_clk),
    .srst(srst),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .timer_one_end_event(trig[0]),
    .event_link_controller(trig[1]),
    .realtime_clock_event(trig[2]),
    .interval_timer_event(trig[3]),
    .comparator_on(comparator_on),
    .conv_start(conv_start),
    .conv_channel(conv_channel),
    .conv_data(conv_data),
    .irq(irq),
    .irq_priority(irq_priority),
    .p1_analog_route(p1_analog_route),
    .p1_pin_in(p1_pin_in),
    .p1_port_data(p1_port_data),
    .p1_pin_out(p1_pin_out),
    .p1_pin_oe(p1_pin_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= {1'b1, 1'b0, a, 8'h00, d};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    bus_req <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge core_clk);
    bus_req <= '0;
    #1 chk(bus_rdata, exp);
  endtask

  // Counts edges until a conversion start is seen, giving up at lim.
  task automatic wait_start(input int lim, output int k);
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (conv_start !== 1'b1 && k < lim);
  endtask

  task automatic pulse(input int i);
    @(posedge core_clk);
    trig <= 4'h1 << i;
    @(posedge core_clk);
    trig <= 4'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({irq, comparator_on, p1_pin_oe}, 16'h0000); // off at reset
    chk({irq_priority, p1_analog_route}, 16'h003F); // defaults
    rd(OFS_IRQ_MASK, 16'h0003); // masked
    rd(OFS_UPPER_LIMIT, 16'h00FF); // limit
    rd(5'h1F, 16'h0000);
    rd(OFS_PORT_IN, 16'h0009); // digital input
  endtask

  task automatic t_gate;
    wr(OFS_MODE_ZERO, 8'h01);
    rd(OFS_MODE_ZERO, 16'h0000); // unclocked
    wr(OFS_CLK_ENABLE, 8'h20);
    wr(OFS_MODE_ZERO, 8'h01);
    rd(OFS_MODE_ZERO, 16'h0001); // clocked
    chk(comparator_on, 1'b1); // comparator alone
    wait_start(20, n);
    chk(n, 20); // run off
    wr(OFS_RESET_CTRL, 8'h20);
    rd(OFS_MODE_ZERO, 16'h0000); // held
    chk(comparator_on, 1'b0); // held
    wr(OFS_RESET_CTRL, 8'h00);
  endtask

  task automatic t_ports;
    wr(OFS_IRQ_PRIO, 8'h01);
    wr(OFS_PORT_ANALOG, 8'h03);
    wr(OFS_PORT_DIR, 8'h05);
    chk({irq_priority, p1_analog_route}, 16'h0013);
    chk({p1_pin_oe, p1_pin_out}, 16'h0088); // pins
  endtask

  // Bring-up in the order software must keep, comparator switched on last.
  task automatic t_init;
    wr(OFS_RESET_CTRL, 8'h20); // reset first
    wr(OFS_RESET_CTRL, 8'h00); // release
    wr(OFS_CLK_ENABLE, 8'h20); // clock on
    wr(OFS_MODE_ZERO, 8'h00); // stop
    wr(OFS_IRQ_MASK, 8'h03); // interrupt setup
    wr(OFS_IRQ_STATUS, 8'h03); // interrupt setup
    wr(OFS_IRQ_PRIO, 8'h01); // interrupt setup
    wr(OFS_PORT_DIR, 8'h0F); // pins
    wr(OFS_MODE_ZERO, 8'h40); // scan mode
    wr(OFS_MODE_ONE, 8'h00); // continuous
    wr(OFS_MODE_TWO, 8'h00); // references
    wr(OFS_UPPER_LIMIT, 8'hFF); // upper
    wr(OFS_LOWER_LIMIT, 8'h00); // lower
    repeat (CYC_SETTLE) @(posedge core_clk);
    wr(OFS_MODE_ZERO, 8'h41); // comparator last
    rd(OFS_MODE_ZERO, 16'h0041); // scan, stopped
    rd(OFS_MODE_TWO, 16'h0000); // references
    rd(OFS_LOWER_LIMIT, 16'h0000); // lower
    chk({comparator_on, irq, p1_pin_oe}, 16'h0020); // ready
  endtask

  task automatic t_sw;
    wr(OFS_MODE_ONE, 8'h20);
    wr(OFS_MODE_ZERO, 8'h81);
    wait_start(10, n);
    chk({n < 10, conv_channel}, 16'h0004); // select starts
    repeat (100) @(posedge core_clk);
    #1 chk(irq, 1'b0); // masked
    rd(OFS_IRQ_STATUS, 16'h0001); // flag
    rd(OFS_RESULT0, 16'h05A3); // channel zero
    rd(OFS_MODE_ZERO, 16'h0001); // one shot
    wr(OFS_IRQ_MASK, 8'h02);
    chk(irq, 1'b1); // unmasked
    wr(OFS_IRQ_STATUS, 8'h01);
    chk(irq, 1'b0); // cleared
  endtask

  task automatic t_scan;
    wr(OFS_MODE_ONE, 8'h00);
    wr(OFS_MODE_ZERO, 8'hC1);
    for (int i = 0; i < 5; i++) begin
      wait_start(200, n);
      chk({n < 200, conv_channel}, {13'h0, 1'b1, 2'(i % 4)});
    end
    wr(OFS_MODE_ZERO, 8'h01);
    wait_start(200, n);
    chk(n, 200); // stopped
    wr(OFS_IRQ_STATUS, 8'h03);
    wr(OFS_MODE_ONE, 8'h20);
    wr(OFS_MODE_ZERO, 8'h89);
    wait_start(20, n);
    chk(n, 20); // refused code
    rd(OFS_IRQ_STATUS, 16'h0002); // refused code
  endtask

  task automatic t_hw;
    wr(OFS_MODE_ONE, 8'hA0);
    wr(OFS_MODE_ZERO, 8'h81);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_MODE_ONE, 8'hA0 | 8'(s));
      pulse((s + 1) % 4);
      wait_start(10, n);
      chk(n, 10); // other source
      pulse(s);
      wait_start(10, d0);
      chk(d0 < 10, 1'b1); // no wait
      repeat (100) @(posedge core_clk);
    end
    wr(OFS_MODE_ONE, 8'hE0);
    pulse(0);
    wait_start(40, n);
    chk(n, d0 + CYC_SETTLE); // wait mode
    repeat (100) @(posedge core_clk);
    wr(OFS_CLK_ENABLE, 8'h00);
    pulse(0);
    wait_start(20, n);
    chk(n, 20); // unclocked
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1;
    t_reset();
    t_gate();
    t_ports();
    t_init();
    t_sw();
    t_scan();
    t_hw();
    end_of_test();
  end
endmodule
